// *** hw/pgm_cfg.svh ***
`ifndef PGM_CFG_SVH
`define PGM_CFG_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define PGM_ADDR_CH2_GAIN     8'h0B
`define PGM_ADDR_CH3_GAIN     8'h0C
`define PGM_ADDR_CH4_GAIN     8'h0D
`define PGM_ADDR_MISC         8'h0E

// ****************************************************************
// Reset values.
// ****************************************************************
`define PGM_GAIN_RESET        8'hA0
`define PGM_MISC_RESET        8'h02

// ****************************************************************
// Field positions of the miscellaneous control register.
// ****************************************************************
`define PGM_MISC_COMBINE_HI   7
`define PGM_MISC_COMBINE_LO   6
`define PGM_MISC_SILENCE_BIT  4
`define PGM_MISC_CAL_BIT      0

// ****************************************************************
// Gain code mapping.
// ****************************************************************
`define PGM_GAIN_UNITY_CODE   9'h0A0
`define PGM_GAIN_MUTE_CODE    8'hFF
`define PGM_GAIN_STEPS_OCTAVE 4
`define PGM_MANT_FRAC_BITS    5'h0E

`endif

// *** hw/pgm_pkg.sv ***
package pgm_pkg;

  typedef enum logic [1:0] {
    PGM_COMBINE_FOUR     = 2'b00,
    PGM_COMBINE_TWO      = 2'b01,
    PGM_COMBINE_ONE      = 2'b10,
    PGM_COMBINE_RESERVED = 2'b11
  } pgm_combine_type;

  typedef struct packed {
    logic [7:0] ch2_gain_code;
    logic [7:0] ch3_gain_code;
    logic [7:0] ch4_gain_code;
    logic [7:0] summing_mute_calibration_control;
    logic [7:0] rd_data;
  } pgm_regs_type;

endpackage : pgm_pkg

// *** hw/pgm_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pgm_cfg.svh"

module pgm_regs (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic [7:0]           addr_i,
  input  wire logic [7:0]           wr_data_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [7:0]           rd_data_o,
  output logic      [2:0][7:0]      gain_code_o,
  output pgm_pkg::pgm_combine_type  channel_combine_select_o,
  output logic                      all_channel_silence_o,
  output logic                      offset_calibrate_trigger_o
);
  import pgm_pkg::*;

  pgm_regs_type st_q;
  pgm_regs_type st_d;
  logic [7:0]   ctl;

  always_comb begin
    st_d         = st_q;
    st_d.rd_data = 8'h00;
    if (wr_i) begin
      case (addr_i)
        `PGM_ADDR_CH2_GAIN: st_d.ch2_gain_code = wr_data_i;
        `PGM_ADDR_CH3_GAIN: st_d.ch3_gain_code = wr_data_i;
        `PGM_ADDR_CH4_GAIN: st_d.ch4_gain_code = wr_data_i;
        `PGM_ADDR_MISC:     st_d.summing_mute_calibration_control = wr_data_i;
        default:            st_d.summing_mute_calibration_control = st_q.summing_mute_calibration_control;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        `PGM_ADDR_CH2_GAIN: st_d.rd_data = st_q.ch2_gain_code;
        `PGM_ADDR_CH3_GAIN: st_d.rd_data = st_q.ch3_gain_code;
        `PGM_ADDR_CH4_GAIN: st_d.rd_data = st_q.ch4_gain_code;
        `PGM_ADDR_MISC:     st_d.rd_data = st_q.summing_mute_calibration_control;
        default:            st_d.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q.ch2_gain_code <= `PGM_GAIN_RESET;
      st_q.ch3_gain_code <= `PGM_GAIN_RESET;
      st_q.ch4_gain_code <= `PGM_GAIN_RESET;
      st_q.summing_mute_calibration_control <= `PGM_MISC_RESET;
      st_q.rd_data       <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  // Reserved mode and reserved bits are stored as written; software keeps them sane.
  assign ctl                        = st_q.summing_mute_calibration_control;
  assign rd_data_o                  = st_q.rd_data;
  assign gain_code_o                = {st_q.ch4_gain_code, st_q.ch3_gain_code, st_q.ch2_gain_code};
  assign channel_combine_select_o   = pgm_combine_type'(ctl[`PGM_MISC_COMBINE_HI:`PGM_MISC_COMBINE_LO]);
  assign all_channel_silence_o      = ctl[`PGM_MISC_SILENCE_BIT];
  assign offset_calibrate_trigger_o = ctl[`PGM_MISC_CAL_BIT];

endmodule // pgm_regs

`default_nettype wire

// *** hw/pgm_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pgm_cfg.svh"

module pgm_top #(
  parameter int SAMPLE_W = 24,
  parameter int NUM_CH   = 3
) (
  input  wire logic                             ref_clk_i,
  input  wire logic                             rst_i,
  input  wire logic [7:0]                       addr_i,
  input  wire logic [7:0]                       wr_data_i,
  input  wire logic                             wr_i,
  input  wire logic                             rd_i,
  output logic      [7:0]                       rd_data_o,
  input  wire logic [NUM_CH-1:0]                sample_valid_i,
  input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0]  sample_i,
  output logic      [NUM_CH-1:0]                sample_valid_o,
  output logic      [NUM_CH-1:0][SAMPLE_W-1:0]  sample_o,
  output pgm_pkg::pgm_combine_type              channel_combine_select_o,
  output logic                                  all_channel_silence_o,
  output logic                                  offset_calibrate_trigger_o
);
  import pgm_pkg::*;

  // ****************************************************************
  // Register bank.
  // ****************************************************************
  logic [2:0][7:0] gain_code;

  pgm_regs u_regs (
    .ref_clk_i                  (ref_clk_i),
    .rst_i                      (rst_i),
    .addr_i                     (addr_i),
    .wr_data_i                  (wr_data_i),
    .wr_i                       (wr_i),
    .rd_i                       (rd_i),
    .rd_data_o                  (rd_data_o),
    .gain_code_o                (gain_code),
    .channel_combine_select_o   (channel_combine_select_o),
    .all_channel_silence_o      (all_channel_silence_o),
    .offset_calibrate_trigger_o (offset_calibrate_trigger_o)
  );

  // ****************************************************************
  // Gain datapath.
  // ****************************************************************
  typedef struct packed {
    logic [NUM_CH-1:0]                vld;
    logic [NUM_CH-1:0][SAMPLE_W-1:0]  smp;
  } pgm_dp_type;

  pgm_dp_type dp_q;
  pgm_dp_type dp_d;

  // Mantissa of one 6 dB span in Q1.14, one entry per 0.375 dB step.
  // Taking each 16-step span as an exact doubling costs about 0.02 dB per span.
  function automatic logic [15:0] pgm_mant(input logic [3:0] r);
    case (r)
      4'h0:    pgm_mant = 16'h4000;
      4'h1:    pgm_mant = 16'h42D3;
      4'h2:    pgm_mant = 16'h45C6;
      4'h3:    pgm_mant = 16'h48DA;
      4'h4:    pgm_mant = 16'h4C10;
      4'h5:    pgm_mant = 16'h4F6C;
      4'h6:    pgm_mant = 16'h52ED;
      4'h7:    pgm_mant = 16'h5695;
      4'h8:    pgm_mant = 16'h5A67;
      4'h9:    pgm_mant = 16'h5E64;
      4'hA:    pgm_mant = 16'h628E;
      4'hB:    pgm_mant = 16'h66E7;
      4'hC:    pgm_mant = 16'h6B72;
      4'hD:    pgm_mant = 16'h702F;
      4'hE:    pgm_mant = 16'h7522;
      default: pgm_mant = 16'h7A4D;
    endcase
  endfunction

  function automatic logic [SAMPLE_W-1:0] pgm_scale(input logic [SAMPLE_W-1:0] s, input logic [7:0] code);
    logic signed [8:0]           steps;
    logic signed [4:0]           oct;
    logic signed [SAMPLE_W+16:0] prod;
    logic signed [SAMPLE_W+27:0] ext;
    logic signed [SAMPLE_W+27:0] sh;
    logic signed [SAMPLE_W+27:0] hi;
    logic signed [SAMPLE_W+27:0] lo;
    steps = $signed(`PGM_GAIN_UNITY_CODE) - $signed({1'b0, code});
    oct   = 5'(steps >>> `PGM_GAIN_STEPS_OCTAVE);
    prod  = $signed(s) * $signed({1'b0, pgm_mant(steps[3:0])});
    ext   = (SAMPLE_W + 28)'(prod);
    if (oct >= 0) begin
      sh = (ext <<< oct[3:0]) >>> `PGM_MANT_FRAC_BITS;
    end else begin
      sh = ext >>> (`PGM_MANT_FRAC_BITS + 5'(-oct));
    end
    hi = (SAMPLE_W + 28)'({1'b0, {(SAMPLE_W-1){1'b1}}});
    lo = -hi - 1;
    // Large boosts clip rather than wrap, so a loud input never flips sign.
    if (sh > hi) begin
      pgm_scale = hi[SAMPLE_W-1:0];
    end else if (sh < lo) begin
      pgm_scale = lo[SAMPLE_W-1:0];
    end else begin
      pgm_scale = sh[SAMPLE_W-1:0];
    end
  endfunction

  always_comb begin
    dp_d = dp_q;
    for (int i = 0; i < NUM_CH; i++) begin
      dp_d.vld[i] = sample_valid_i[i];
      if (!sample_valid_i[i]) begin
        dp_d.smp[i] = dp_q.smp[i];
      end else if (all_channel_silence_o) begin
        dp_d.smp[i] = '0;
      end else if (gain_code[i] == `PGM_GAIN_MUTE_CODE) begin
        dp_d.smp[i] = '0;
      end else begin
        dp_d.smp[i] = pgm_scale(sample_i[i], gain_code[i]);
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dp_q <= '0;
    end else begin
      dp_q <= dp_d;
    end
  end

  assign sample_valid_o = dp_q.vld;
  assign sample_o       = dp_q.smp;

endmodule // pgm_top

`default_nettype wire

// *** sim/pgm_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks.
// ****
module pgm_top_sva #(
  parameter int SAMPLE_W = 24,
  parameter int NUM_CH   = 3
) (
  input wire logic                           ref_clk_i,
  input wire logic                           rst_i,
  input wire logic [7:0]                     addr_i,
  input wire logic [7:0]                     wr_data_i,
  input wire logic                           wr_i,
  input wire logic                           rd_i,
  input wire logic [7:0]                     rd_data_o,
  input wire logic [NUM_CH-1:0]              sample_valid_i,
  input wire logic [NUM_CH-1:0][SAMPLE_W-1:0] sample_i,
  input wire logic [NUM_CH-1:0]              sample_valid_o,
  input wire logic [NUM_CH-1:0][SAMPLE_W-1:0] sample_o,
  input wire pgm_pkg::pgm_combine_type       channel_combine_select_o,
  input wire logic                           all_channel_silence_o,
  input wire logic                           offset_calibrate_trigger_o
);
  import pgm_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] g2_q;
  logic       wm;
  assign wm = wr_i && addr_i == 8'h0E;
  // Shadow of the channel 2 code, since the stage hides it.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) g2_q <= 8'hA0;
    else if (wr_i && addr_i == 8'h0B) g2_q <= wr_data_i;
  end
  a_rd_idle: assert property (!$past(rd_i) |-> rd_data_o == 8'h00) else $error("read data not idle");
  a_ch2_read: assert property (rd_i && addr_i == 8'h0B |=> rd_data_o == $past(g2_q)) else $error("ch2 read");
  a_unity_pass: assert property (sample_valid_o[0] && $past(g2_q) == 8'hA0 && !$past(all_channel_silence_o)
    |-> sample_o[0] == $past(sample_i[0])) else $error("unity gain");
  a_mute_code: assert property (sample_valid_o[0] && $past(g2_q) == 8'hFF |-> sample_o[0] == '0)
    else $error("mute code");
  a_silence_zero: assert property (sample_valid_o[1] && $past(all_channel_silence_o) |-> sample_o[1] == '0)
    else $error("silence");
  a_combine_map: assert property (wm |=> channel_combine_select_o == $past(wr_data_i[7:6])) else $error("mode");
  a_silence_map: assert property (wm |=> all_channel_silence_o == $past(wr_data_i[4])) else $error("mute");
  a_cal_map: assert property (wm |=> offset_calibrate_trigger_o == $past(wr_data_i[0])) else $error("cal");
  cover property (wm ##1 all_channel_silence_o);
  cover property (sample_valid_o[0] && $past(g2_q) == 8'h00);
  cover property (rd_i ##1 rd_data_o != 8'h00);
endmodule // pgm_top_sva
bind pgm_top pgm_top_sva #(
  .SAMPLE_W (SAMPLE_W),
  .NUM_CH   (NUM_CH)
) u_sva (
  .ref_clk_i                  (ref_clk_i),
  .rst_i                      (rst_i),
  .addr_i                     (addr_i),
  .wr_data_i                  (wr_data_i),
  .wr_i                       (wr_i),
  .rd_i                       (rd_i),
  .rd_data_o                  (rd_data_o),
  .sample_valid_i             (sample_valid_i),
  .sample_i                   (sample_i),
  .sample_valid_o             (sample_valid_o),
  .sample_o                   (sample_o),
  .channel_combine_select_o   (channel_combine_select_o),
  .all_channel_silence_o      (all_channel_silence_o),
  .offset_calibrate_trigger_o (offset_calibrate_trigger_o)
);
`default_nettype wire

// *** sim/pgm_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench.
// ****
module pgm_top_tb;
  import pgm_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       ad  = 8'h00;
  logic [7:0]       wd  = 8'h00;
  logic             we  = 1'b0;
  logic             re  = 1'b0;
  logic [2:0]       vi  = 3'b000;
  logic [2:0][23:0] si  = '0;
  logic [7:0]       rdo;
  logic [2:0]       vo;
  logic [2:0][23:0] so;
  pgm_combine_type  cmb;
  logic             sil;
  logic             cal;
  int               err_count = 0;
  int               n_checks  = 0;
  pgm_top dut (.ref_clk_i(clk), .rst_i(rst), .addr_i(ad), .wr_data_i(wd), .wr_i(we), .rd_i(re),
    .rd_data_o(rdo), .sample_valid_i(vi), .sample_i(si), .sample_valid_o(vo), .sample_o(so),
    .channel_combine_select_o(cmb), .all_channel_silence_o(sil), .offset_calibrate_trigger_o(cal));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    re <= 1'b1;
    ad <= a;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    d = rdo;
  endtask
  // Each step is rebuilt from its decibel value; sixteen steps count as one exact doubling.
  function automatic logic [23:0] mdl(input logic [23:0] s, input logic [7:0] code, input bit m);
    longint v;
    int     st;
    int     r;
    int     k;
    st = 160 - int'(code);
    r  = st & 15;
    k  = (st - r) / 16;
    v  = longint'($signed(s)) * longint'(16384.0 * 10.0 ** (0.375 * r / 20.0));
    v  = (k >= 0) ? ((v <<< k) >>> 14) : (v >>> (14 - k));
    if (v > 64'sh7F_FFFF) v = 64'sh7F_FFFF;
    if (v < -64'sh80_0000) v = -64'sh80_0000;
    return (m || code == 8'hFF) ? 24'h00_0000 : v[23:0];
  endfunction
  // Channels get neighbouring codes so a shared gain register would show up.
  task automatic smp(input logic [7:0] code, input bit m);
    logic [2:0][23:0] e;
    logic [23:0]      s;
    for (int c = 0; c < 3; c++) wr(8'h0B + 8'(c), code + 8'(c));
    for (int c = 0; c < 3; c++) begin
      s = 24'($urandom);
      si[c] <= s;
      e[c] = mdl(s, code + 8'(c), m);
    end
    vi <= 3'b111;
    @(posedge clk);
    vi <= 3'b000;
    @(negedge clk);
    chk(32'(vo), 32'h7);
    for (int c = 0; c < 3; c++) chk(32'(so[c]), 32'(e[c]));
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    logic [7:0] d;
    logic [7:0] x;
    void'($urandom(32'h3ffa_f6b1));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'({cmb, sil, cal}), 32'h0);
    chk(32'({vo, so[0]}), 32'h0);
    for (int a = 11; a <= 14; a++) begin
      rd(8'(a), d);
      chk(32'(d), (a == 14) ? 32'h2 : 32'hA0);
    end
    wr(8'h0A, 8'h5A);
    rd(8'h0A, d);
    chk(32'(d), 32'h0);
    for (int a = 11; a <= 13; a++) begin
      x = 8'($urandom);
      wr(8'(a), x);
      rd(8'(a), d);
      chk(32'(d), 32'(x));
    end
    for (int k = -5; k <= 10; k++) smp(8'(160 - 16 * k), 1'b0);
    for (int j = 0; j < 24; j++) smp(8'($urandom), 1'b0);
    smp(8'hFF, 1'b0);
    // Reserved bits keep their reset pattern and mode 11 is never set.
    for (int i = 0; i < 6; i++) begin
      x = {2'(i / 2), 1'b0, i[0], 3'b001, ~i[0]};
      wr(8'h0E, x);
      rd(8'h0E, d);
      chk(32'(d), 32'(x));
      chk(32'({cmb, sil, cal}), 32'({x[7:6], x[4], x[0]}));
      smp(8'hA0, i[0]);
    end
    tally_and_finish;
  end
endmodule // pgm_top_tb
`default_nettype wire
